// >>> cause_flag_bank.sv
// sticky cause flags with write-one-to-clear and enable gating
`timescale 1ns/1ps
module cause_flag_bank (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic [15:0] present_mask,
    input wire logic [15:0] set_bits,
    input wire logic [15:0] clear_bits,
    input wire logic enable_we,
    input wire logic [15:0] enable_wdata,
    output logic [15:0] flags,
    output logic [15:0] enables,
    output logic irq_request
);
    logic [15:0] next_flags;
    logic [15:0] next_enables;

    // set beats clear in the same cycle
    assign next_flags = ((flags & ~clear_bits) | set_bits) & present_mask;
    assign next_enables = enable_we ? (enable_wdata & present_mask) : enables;
    assign irq_request = |(flags & enables);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= timer_irq_pkg::flags_reset;
            enables <= timer_irq_pkg::enables_reset;
        end else if (clk_en) begin
            flags <= next_flags;
            enables <= next_enables;
        end
    end

    property p_set_holds;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && |(set_bits & present_mask)) |=> ((flags & $past(set_bits & present_mask))
            == $past(set_bits & present_mask));
    endproperty
    a_set_holds: assert property (p_set_holds) else $error("cause event lost");

    property p_clear_one;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && |(clear_bits & ~set_bits & flags))
            |=> ((flags & $past(clear_bits & ~set_bits)) == 16'h0000);
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("flag not cleared");

    property p_hold_no_event;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && set_bits == 16'h0000 && clear_bits == 16'h0000) |=> $stable(flags);
    endproperty
    a_hold_no_event: assert property (p_hold_no_event) else $error("flag moved");

    property p_absent_zero;
        @(posedge hclk) disable iff (!hresetn)
        ((flags | enables) & ~present_mask) == 16'h0000;
    endproperty
    a_absent_zero: assert property (p_absent_zero) else $error("absent bit set");

    property p_enable_write;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && enable_we) |=> enables == $past(enable_wdata & present_mask);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable wrong");

    property p_irq_or;
        @(posedge hclk) disable iff (!hresetn)
        irq_request == ((flags & enables) != 16'h0000);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq mismatch");
endmodule : cause_flag_bank

// >>> tb_top.sv
// self-checking bench for the timer status and interrupt register block
`timescale 1ns/1ps
module tb_top;
    localparam logic [5:0] present = 6'h1f;
    typedef struct packed {
        logic [5:0] pins;
        logic up;
        logic run;
        logic [13:0] ev;
        logic [15:0] cs;
        logic [15:0] fl;
    } row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = timer_irq_pkg::hsize_word;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [5:0] capture_input_pin = 6'h00;
    logic count_up = 1'b0;
    logic counter_running = 1'b0;
    timer_irq_pkg::cause_events_t cause_events = '0;
    logic [15:0] cc_ctl [6];
    logic channel_irq;
    logic irq;
    logic [31:0] rd;
    int error_cnt = 0;
    int n_checks = 0;
    row_t rows [4];

    timer_status_irq_regs #(.unit_present(present)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .capture_input_pin(capture_input_pin), .count_up(count_up),
        .counter_running(counter_running), .cause_events(cause_events),
        .compare_capture_control(cc_ctl), .channel_irq(channel_irq), .irq(irq)
    );

    initial begin
        forever #50 hclk = ~hclk;
    end

    task automatic test_done();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one single word transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= timer_irq_pkg::htrans_nonseq;
        hwrite <= wr;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin
            error_cnt++;
            test_done();
        end
    endtask : xfer

    task automatic pulse(input logic [13:0] ev);
        cause_events <= timer_irq_pkg::cause_events_t'(ev);
        @(posedge hclk);
        cause_events <= '0;
        repeat (2) @(posedge hclk);
    endtask : pulse

    initial begin
        rows[0] = '{6'h3f, 1'b1, 1'b0, 14'h3fff, 16'h007e, 16'h0fff};
        rows[1] = '{6'h15, 1'b0, 1'b1, 14'h0001, 16'h0055, 16'h0001};
        rows[2] = '{6'h2a, 1'b1, 1'b1, 14'h2aaa, 16'h002b, 16'h0332};
        rows[3] = '{6'h00, 1'b0, 1'b0, 14'h1555, 16'h0000, 16'h0ccd};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            capture_input_pin <= rows[i].pins;
            count_up <= rows[i].up;
            counter_running <= rows[i].run;
            pulse(rows[i].ev);
            repeat (2) @(posedge hclk);
            xfer(1'b0, timer_irq_pkg::off_counter_status, 32'h0000_0000);
            check("counter_status", rd, {16'h0000, rows[i].cs});
            check("hresp", {31'h0, hresp}, 32'h0000_0000);
            xfer(1'b0, timer_irq_pkg::off_interrupt_flags, 32'h0000_0000);
            check("interrupt_flags", rd, {16'h0000, rows[i].fl});
            xfer(1'b1, timer_irq_pkg::off_interrupt_flags, 32'h0000_ffff);
            xfer(1'b0, timer_irq_pkg::off_interrupt_flags, 32'h0000_0000);
            check("flags_cleared", rd, 32'h0000_0000);
        end
        // partial clear leaves the other flag pending
        pulse(14'h0003);
        xfer(1'b1, timer_irq_pkg::off_interrupt_flags, 32'h0000_0001);
        xfer(1'b0, timer_irq_pkg::off_interrupt_flags, 32'h0000_0000);
        check("partial_clear", rd, 32'h0000_0002);
        xfer(1'b1, timer_irq_pkg::off_interrupt_enables, 32'h0000_ffff);
        xfer(1'b0, timer_irq_pkg::off_interrupt_enables, 32'h0000_0000);
        check("interrupt_enables", rd, 32'h0000_0fff);
        check("channel_irq_on", {31'h0, channel_irq}, 32'h0000_0001);
        xfer(1'b1, timer_irq_pkg::off_interrupt_enables, 32'h0000_0001);
        @(posedge hclk);
        check("channel_irq_gated", {31'h0, channel_irq}, 32'h0000_0000);
        xfer(1'b1, timer_irq_pkg::off_interrupt_flags, 32'h0000_ffff);
        xfer(1'b0, timer_irq_pkg::off_irq_status, 32'h0000_0000);
        xfer(1'b1, timer_irq_pkg::off_irq_mask, 32'h0000_0000);
        pulse(14'h0001);
        check("channel_irq_zero", {31'h0, channel_irq}, 32'h0000_0001);
        check("irq_masked", {31'h0, irq}, 32'h0000_0000);
        xfer(1'b1, timer_irq_pkg::off_irq_mask, 32'h0000_0001);
        @(posedge hclk);
        check("irq_unmasked", {31'h0, irq}, 32'h0000_0001);
        xfer(1'b0, timer_irq_pkg::off_irq_status, 32'h0000_0000);
        check("irq_status_rise", rd, 32'h0000_0001);
        @(posedge hclk);
        check("irq_read_clear", {31'h0, irq}, 32'h0000_0000);
        xfer(1'b1, timer_irq_pkg::off_irq_mask, 32'h0000_0002);
        counter_running <= 1'b1;
        @(posedge hclk);
        counter_running <= 1'b0;
        repeat (3) @(posedge hclk);
        check("irq_stopped", {31'h0, irq}, 32'h0000_0001);
        xfer(1'b0, timer_irq_pkg::off_irq_status, 32'h0000_0000);
        check("irq_status_stop", rd, 32'h0000_0002);
        // unmapped place reads 0 and takes no write
        xfer(1'b1, 8'h40, 32'h0000_ffff);
        xfer(1'b0, 8'h40, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        for (int u = 0; u < 6; u++) begin
            xfer(1'b1, timer_irq_pkg::off_cc_control_base + 8'(4 * u), 32'h0000_ffff);
            xfer(1'b0, timer_irq_pkg::off_cc_control_base + 8'(4 * u), 32'h0000_0000);
            check("cc_control_read", rd, present[u] ? 32'h0000_ff7f : 32'h0000_0000);
            check("cc_control_port", {16'h0000, cc_ctl[u]}, present[u] ? 32'h0000_ff7f : 32'h0);
        end
        // a cause while the clock enable is low is not recorded
        clk_en <= 1'b0;
        pulse(14'h0002);
        clk_en <= 1'b1;
        xfer(1'b0, timer_irq_pkg::off_interrupt_flags, 32'h0000_0000);
        check("frozen_flags", rd, 32'h0000_0001);
        // second reset with a flag and an enable both set
        pulse(14'h0001);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check("hrdata_reset", hrdata, 32'h0000_0000);
        check("irq_reset", {30'h0, channel_irq, irq}, 32'h0000_0000);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, timer_irq_pkg::off_interrupt_flags, 32'h0000_0000);
        check("flags_reset", rd, 32'h0000_0000);
        xfer(1'b0, timer_irq_pkg::off_interrupt_enables, 32'h0000_0000);
        check("enables_reset", rd, 32'h0000_0000);
        xfer(1'b0, timer_irq_pkg::off_cc_control_base, 32'h0000_0000);
        check("cc_control_reset", rd, 32'h0000_0000);
        test_done();
    end
endmodule : tb_top

// >>> timer_irq_pkg.sv
// constants and carrier types for the timer status and interrupt block
package timer_irq_pkg;
    localparam int unit_count = 6;
    localparam int flag_count = 14;
    // byte offsets on the register bus
    localparam logic [7:0] off_counter_status = 8'h00;
    localparam logic [7:0] off_interrupt_flags = 8'h04;
    localparam logic [7:0] off_interrupt_enables = 8'h08;
    localparam logic [7:0] off_cc_control_base = 8'h10;
    localparam logic [7:0] off_irq_status = 8'h28;
    localparam logic [7:0] off_irq_mask = 8'h2c;
    // counter status field positions
    localparam int pos_running = 0;
    localparam int pos_direction = 1;
    localparam int pos_capture_level = 2;
    // interrupt flag field positions
    localparam int pos_counter_zero = 0;
    localparam int pos_counter_max = 1;
    localparam int pos_unit_base = 2;
    localparam logic [15:0] flags_reset = 16'h0000;
    localparam logic [15:0] enables_reset = 16'h0000;
    localparam logic [15:0] cc_control_reset = 16'h0000;
    localparam logic [15:0] cc_control_mask = 16'hff7f;
    localparam logic [15:0] flag_field_mask = 16'h3fff;
    localparam logic [1:0] irq_status_reset = 2'h0;
    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [2:0] hsize_word = 3'h2;

    typedef struct packed {
        logic [5:0] capture_overwrite;
        logic [5:0] compare_capture;
        logic counter_max;
        logic counter_zero;
    } cause_events_t;

    typedef struct packed {
        logic [5:0] capture_level;
        logic count_up;
        logic counter_running;
    } counter_state_t;

    typedef enum logic [1:0] {
        phase_idle,
        phase_write,
        phase_read
    } bus_phase_t;
endpackage : timer_irq_pkg

// >>> timer_status_irq_regs.sv
// status and interrupt registers of one timer channel, ahb-lite slave
//
// Notes on behaviour
// - status bits 7..2 show the live level of capture inputs 0..5.
// - a capture input that is not present always reads 0.
// - status bit 1 shows count direction, 1 up, 0 down.
// - status bit 0 reads 1 while the counter runs.
// - a cause sets its flag, which holds until software clears it.
// - writing 1 clears a flag, 0 leaves it; flags reset to 0.
// - bit 0 zero, bit 1 max, units on bits 2..13, bits 15..14 zero.
// - one enable per flag at the same position, resets to 0.
// - flags and enables of absent units are fixed at 0.
`timescale 1ns/1ps
module timer_status_irq_regs #(
    parameter logic [5:0] unit_present = 6'h3f
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [5:0] capture_input_pin,
    input wire logic count_up,
    input wire logic counter_running,
    input wire timer_irq_pkg::cause_events_t cause_events,
    output logic [15:0] compare_capture_control [6],
    output logic channel_irq,
    output logic irq
);
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    timer_irq_pkg::counter_state_t state_now;
    timer_irq_pkg::bus_phase_t phase;
    logic [7:0] data_addr;
    logic [15:0] flags;
    logic [15:0] enables;
    logic [15:0] present_mask;
    logic [15:0] set_bits;
    logic [15:0] clear_bits;
    logic [15:0] status_word;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] irq_events;
    logic [1:0] irq_clear;
    logic irq_request;
    logic prev_irq_request;
    logic prev_running;
    logic addr_valid;
    logic write_phase;
    logic read_phase;
    logic [31:0] read_mux;
    logic [2:0] cc_index;
    logic cc_hit;
    logic [3:0] wr_slot;
    logic [3:0] rd_slot;
    logic [2:0] rd_cc_index;
    logic rd_cc_hit;

    // spread unit presence into the flag layout
    function automatic logic [15:0] unit_spread(input logic [5:0] units);
        logic [15:0] m;
        m = 16'h0003;
        for (int i = 0; i < timer_irq_pkg::unit_count; i++) begin
            m[timer_irq_pkg::pos_unit_base + 2 * i] = units[i];
            m[timer_irq_pkg::pos_unit_base + 2 * i + 1] = units[i];
        end
        return m;
    endfunction : unit_spread

    // map cause events to flag positions
    function automatic logic [15:0] event_bits(input timer_irq_pkg::cause_events_t ev);
        logic [15:0] b;
        b = 16'h0000;
        b[timer_irq_pkg::pos_counter_zero] = ev.counter_zero;
        b[timer_irq_pkg::pos_counter_max] = ev.counter_max;
        for (int i = 0; i < timer_irq_pkg::unit_count; i++) begin
            b[timer_irq_pkg::pos_unit_base + 2 * i] = ev.compare_capture[i];
            b[timer_irq_pkg::pos_unit_base + 2 * i + 1] = ev.capture_overwrite[i];
        end
        return b;
    endfunction : event_bits

    // control word slot of an address: bit 3 hit, bits 2..0 unit index
    function automatic logic [3:0] cc_decode(input logic [7:0] a);
        logic [7:0] rel;
        logic hit;
        rel = a - timer_irq_pkg::off_cc_control_base;
        hit = a >= timer_irq_pkg::off_cc_control_base && a < timer_irq_pkg::off_irq_status
            && a[1:0] == 2'h0;
        return {hit, rel[4:2]};
    endfunction : cc_decode

    // pins are asynchronous; two stages before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else if (clk_en) begin
            pin_meta <= capture_input_pin;
            pin_sync <= pin_meta;
        end
    end

    assign state_now.capture_level = pin_sync & unit_present;
    assign state_now.count_up = count_up;
    assign state_now.counter_running = counter_running;

    assign status_word = {8'h00, state_now.capture_level, state_now.count_up,
        state_now.counter_running};

    assign present_mask = unit_spread(unit_present) & timer_irq_pkg::flag_field_mask;
    assign set_bits = event_bits(cause_events);
    assign write_phase = (phase == timer_irq_pkg::phase_write);
    assign read_phase = (phase == timer_irq_pkg::phase_read);
    assign clear_bits = (write_phase && data_addr == timer_irq_pkg::off_interrupt_flags)
        ? hwdata[15:0] : 16'h0000;

    cause_flag_bank flag_bank (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .present_mask(present_mask),
        .set_bits(set_bits),
        .clear_bits(clear_bits),
        .enable_we(write_phase && data_addr == timer_irq_pkg::off_interrupt_enables),
        .enable_wdata(hwdata[15:0]),
        .flags(flags),
        .enables(enables),
        .irq_request(irq_request)
    );

    assign channel_irq = irq_request;

    // bus address phase
    assign addr_valid = hsel && hready && htrans == timer_irq_pkg::htrans_nonseq;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= timer_irq_pkg::phase_idle;
            data_addr <= 8'h00;
        end else if (clk_en) begin
            if (addr_valid) begin
                phase <= hwrite ? timer_irq_pkg::phase_write : timer_irq_pkg::phase_read;
                data_addr <= haddr[7:0];
            end else begin
                phase <= timer_irq_pkg::phase_idle;
            end
        end
    end

    // compare/capture control, one word per unit
    assign wr_slot = cc_decode(data_addr);
    assign cc_hit = wr_slot[3];
    assign cc_index = wr_slot[2:0];
    assign rd_slot = cc_decode(haddr[7:0]);
    assign rd_cc_hit = rd_slot[3];
    assign rd_cc_index = rd_slot[2:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < timer_irq_pkg::unit_count; i++) begin
                compare_capture_control[i] <= timer_irq_pkg::cc_control_reset;
            end
        end else if (clk_en && write_phase && cc_hit && unit_present[cc_index]) begin
            compare_capture_control[cc_index] <= hwdata[15:0] & timer_irq_pkg::cc_control_mask;
        end
    end

    // system interrupt wrapper: bit 0 request rose, bit 1 counter stopped
    assign irq_events = {prev_running && !counter_running, irq_request && !prev_irq_request};
    // clear only what the read returned, so a newer event survives
    assign irq_clear = (read_phase && data_addr == timer_irq_pkg::off_irq_status)
        ? hrdata[1:0] : 2'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= timer_irq_pkg::irq_status_reset;
            irq_mask <= timer_irq_pkg::irq_status_reset;
            prev_irq_request <= 1'b0;
            prev_running <= 1'b0;
        end else if (clk_en) begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
            prev_irq_request <= irq_request;
            prev_running <= counter_running;
            if (write_phase && data_addr == timer_irq_pkg::off_irq_mask) begin
                irq_mask <= hwdata[1:0];
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

    // read mux on the address-phase address; a read right behind a write sees old data
    always_comb begin
        read_mux = 32'h0000_0000;
        if (rd_cc_hit) begin
            read_mux = {16'h0000, compare_capture_control[rd_cc_index]};
        end else begin
            case (haddr[7:0])
                timer_irq_pkg::off_counter_status: read_mux = {16'h0000, status_word};
                timer_irq_pkg::off_interrupt_flags: read_mux = {16'h0000, flags};
                timer_irq_pkg::off_interrupt_enables: read_mux = {16'h0000, enables};
                timer_irq_pkg::off_irq_status: read_mux = {30'h0, irq_status};
                timer_irq_pkg::off_irq_mask: read_mux = {30'h0, irq_mask};
                default: read_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en) begin
            hrdata <= 32'h0000_0000;
            // loaded at the address phase, stands through the data phase
            if (addr_valid && !hwrite) begin
                hrdata <= read_mux;
            end
        end
    end

    property p_status_levels;
        @(posedge hclk) disable iff (!hresetn)
        status_word[7:2] == (pin_sync & unit_present);
    endproperty
    a_status_levels: assert property (p_status_levels) else $error("level bits wrong");

    property p_absent_pin;
        @(posedge hclk) disable iff (!hresetn)
        (status_word[7:2] & ~unit_present) == 6'h00;
    endproperty
    a_absent_pin: assert property (p_absent_pin) else $error("absent pin reads 1");

    property p_direction;
        @(posedge hclk) disable iff (!hresetn)
        status_word[1] == count_up;
    endproperty
    a_direction: assert property (p_direction) else $error("direction wrong");

    property p_running;
        @(posedge hclk) disable iff (!hresetn)
        status_word[0] == counter_running && status_word[15:8] == 8'h00;
    endproperty
    a_running: assert property (p_running) else $error("running bit wrong");

    property p_top_zero;
        @(posedge hclk) disable iff (!hresetn)
        flags[15:14] == 2'h0 && enables[15:14] == 2'h0;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("bits 15..14 set");

    property p_zero_event;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && cause_events.counter_zero) |=> flags[0];
    endproperty
    a_zero_event: assert property (p_zero_event) else $error("zero flag missed");

    property p_flags_read;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && addr_valid && !hwrite && haddr[7:0] == timer_irq_pkg::off_interrupt_flags)
            |=> hrdata == {16'h0000, $past(flags)};
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("flag read data wrong");

    property p_enables_read;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && addr_valid && !hwrite && haddr[7:0] == timer_irq_pkg::off_interrupt_enables)
            |=> hrdata == {16'h0000, $past(enables)};
    endproperty
    a_enables_read: assert property (p_enables_read) else $error("enable read wrong");

    property p_status_read;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && addr_valid && !hwrite && haddr[7:0] == timer_irq_pkg::off_counter_status)
            |=> hrdata[1:0] == {$past(count_up), $past(counter_running)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_level_sync;
        @(posedge hclk) disable iff (!hresetn)
        clk_en |=> pin_meta == $past(capture_input_pin) && pin_sync == $past(pin_meta);
    endproperty
    a_level_sync: assert property (p_level_sync) else $error("pin sync wrong");

    property p_enables_hold;
        @(posedge hclk) disable iff (!hresetn)
        !(clk_en && write_phase && data_addr == timer_irq_pkg::off_interrupt_enables)
            |=> $stable(enables);
    endproperty
    a_enables_hold: assert property (p_enables_hold) else $error("enable moved");

    property p_freeze;
        @(posedge hclk) disable iff (!hresetn)
        !clk_en |=> $stable(flags) && $stable(enables) && $stable(pin_sync);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule : timer_status_irq_regs
